// ===== hdl/ursel_top.sv
// UART host register bank with bank selection and access side effects.
// Assumes one-cycle synchronous read and write strobes from the host.
//
// What this block does
// [R1] Divisor open: offsets 0,1 reach divisor bytes
// [R2] Divisor open, enhanced on: offset 2 fraction
// [R3] Zero divisor: read revision and identification codes
// [R4] Divisor closed: offset 0 receive/transmit characters
// [R5] Divisor closed: offset 1 interrupt enable
// [R6] Offset 2: interrupt status read, queue control write
// [R7] Offset 3 line control; offset 4 modem control
// [R8] Offset 5 line status, writes ignored
// [R9] Offset 6 modem status; enhanced write port
// [R10] Feature bit clear: offset 7 scratch
// [R11] Feature bit set: level read, mode write
// [R12] Bank key: offset 0 level read, threshold write
// [R13] Bank key: feature control, enhanced function
// [R14] Bank key: offsets 4-7 flow characters
// [R15] Enhanced bits writable only with enhanced on
// [R16] Host writes key to open, restores to close
`timescale 1ns/100ps
`default_nettype none
`include "ursel_params.svh"
module ursel_top #(
    parameter logic [7:0] REV_CODE = 8'h3C, // Arbitrary value
    parameter logic [7:0] IDENT_CODE = 8'hC3 // Arbitrary value
) (
    input wire logic CLK,
    input wire logic RST,
    input wire ursel_pkg::ursel_req_t HOST_REQ,
    input wire ursel_pkg::ursel_core_t CORE_IN,
    output logic [7:0] RD_DATA,
    output logic RD_VALID,
    output ursel_pkg::ursel_cfg_t CFG,
    output logic TX_PUSH,
    output logic [7:0] TX_CHAR,
    output logic RX_POP,
    output logic QCTL_WR,
    output logic [7:0] QCTL
);
    import ursel_pkg::*;

    ursel_state_t s;
    ursel_state_t next_s;
    ursel_sel_t rd_sel;
    ursel_sel_t wr_sel;
    logic [7:0] rd_byte;
    logic [7:0] wd;
    logic enh;
    logic lvl_sel;
    logic div_zero;
    logic bank;

    // Bank inputs all come from registers, so a line control write
    // only moves the map from the next access on
    assign enh = s.cfg.efunc[`URSEL_EFUNC_ENH_BIT];
    assign lvl_sel = s.cfg.feat[`URSEL_FEAT_LVL_BIT];
    assign div_zero = (s.cfg.div_lo == `URSEL_DIV_ZERO) && (s.cfg.div_hi == `URSEL_DIV_ZERO);
    assign bank = (s.cfg.lctl == `URSEL_BANK_KEY);
    assign wd = HOST_REQ.wdata;

    // Offset decode for the current bank
    ursel_decode u_decode (
        .addr(HOST_REQ.addr),
        .lctl(s.cfg.lctl),
        .enh(enh),
        .lvl_sel(lvl_sel),
        .div_zero(div_zero),
        .rd_sel(rd_sel),
        .wr_sel(wr_sel)
    );

    // Byte for the read path
    ursel_rdmux u_rdmux (
        .sel(rd_sel),
        .cfg(s.cfg),
        .core(CORE_IN),
        .rev(REV_CODE),
        .ident(IDENT_CODE),
        .enh(enh),
        .rd_byte(rd_byte)
    );

    // Keeps masked bits when enhanced functions are off
    function automatic logic [7:0] merge_enh(input logic [7:0] old_v, input logic [7:0] new_v,
                                            input logic [7:0] mask, input logic en);
        merge_enh = en ? new_v : ((new_v & ~mask) | (old_v & mask));
    endfunction : merge_enh

    // Next state: read capture, register writes and side-effect pulses
    always_comb begin
        next_s = s;
        next_s.rvalid = 1'b0;
        next_s.tx_push = 1'b0;
        next_s.rx_pop = 1'b0;
        next_s.qctl_wr = 1'b0;
        if (HOST_REQ.rd) begin
            next_s.rdata = rd_byte; // R3 R8 R11 R12
            next_s.rvalid = 1'b1;
            // A receive read consumes the character
            if (rd_sel == SEL_HOLD) begin
                next_s.rx_pop = 1'b1; // R4
            end
        end
        if (HOST_REQ.wr) begin
            unique case (wr_sel)
                SEL_DIV_LO: next_s.cfg.div_lo = wd; // R1
                SEL_DIV_HI: next_s.cfg.div_hi = wd; // R1
                SEL_DIV_FRAC: next_s.cfg.div_frac = wd; // R2
                SEL_HOLD: begin
                    next_s.tx_push = 1'b1; // R4
                    next_s.tx_char = wd;
                end
                SEL_IEN: next_s.cfg.ien = merge_enh(s.cfg.ien, wd, `URSEL_IEN_ENH_MASK, enh); // R5 R15
                SEL_QCTL: begin
                    next_s.qctl_wr = 1'b1; // R6
                    next_s.qctl = wd;
                end
                SEL_LCTL: next_s.cfg.lctl = wd; // R7
                SEL_MCTL: next_s.cfg.mctl = merge_enh(s.cfg.mctl, wd, `URSEL_MCTL_ENH_MASK, enh); // R7 R15
                SEL_MSCTL: next_s.cfg.msctl = wd & `URSEL_MSCTL_MASK; // R9
                SEL_SCRATCH: next_s.cfg.scratch = wd; // R10
                SEL_MODE: next_s.cfg.mode = wd; // R11
                SEL_THRESH: next_s.cfg.thresh = wd; // R12
                SEL_FEAT: next_s.cfg.feat = wd; // R13
                SEL_EFUNC: next_s.cfg.efunc = wd; // R13
                SEL_RES1: next_s.cfg.res1 = wd; // R14
                SEL_RES2: next_s.cfg.res2 = wd; // R14
                SEL_PAUSE1: next_s.cfg.pause1 = wd; // R14
                SEL_PAUSE2: next_s.cfg.pause2 = wd; // R14
                // Read-only offsets and unmapped writes change nothing
                default: next_s = next_s; // R8
            endcase
        end
    end

    // State register; everything clears, so the map starts compatible
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign RD_DATA = s.rdata;
    assign RD_VALID = s.rvalid;
    assign CFG = s.cfg;
    assign TX_PUSH = s.tx_push;
    assign TX_CHAR = s.tx_char;
    assign RX_POP = s.rx_pop;
    assign QCTL_WR = s.qctl_wr;
    assign QCTL = s.qctl;

    // Checks on the decode and its effects, one cycle after the access; the receive pop check also looks one cycle further
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // Access qualifiers used by the checks below
    logic dl_open;
    assign dl_open = s.cfg.lctl[`URSEL_LCTL_DIV_BIT] && !bank;

    sequence wr_at(logic [2:0] a);
        HOST_REQ.wr && (HOST_REQ.addr == a);
    endsequence

    sequence rd_at(logic [2:0] a);
        HOST_REQ.rd && (HOST_REQ.addr == a);
    endsequence

    sequence read_returns(logic [7:0] v);
        RD_VALID && (RD_DATA == v);
    endsequence

    div_lo_write_a: assert property ( // R1
        wr_at(`URSEL_A_HOLD) and dl_open |=> CFG.div_lo == $past(HOST_REQ.wdata) && !TX_PUSH)
        else $error("divisor low byte not written");

    div_hi_read_a: assert property ( // R1
        rd_at(`URSEL_A_IEN) and dl_open && !div_zero |=> read_returns($past(s.cfg.div_hi)))
        else $error("divisor high byte not read back");

    div_frac_write_a: assert property ( // R2
        wr_at(`URSEL_A_ISTAT) and dl_open && enh |=> CFG.div_frac == $past(HOST_REQ.wdata) && !QCTL_WR)
        else $error("fractional divisor not written");

    rev_code_a: assert property ( // R3
        rd_at(`URSEL_A_HOLD) and dl_open && div_zero |=> read_returns(REV_CODE))
        else $error("revision code not returned");

    ident_code_a: assert property ( // R3
        rd_at(`URSEL_A_IEN) and dl_open && div_zero |=> read_returns(IDENT_CODE))
        else $error("identification code not returned");

    rx_pop_a: assert property ( // R4
        rd_at(`URSEL_A_HOLD) and !s.cfg.lctl[`URSEL_LCTL_DIV_BIT]
        |=> (RX_POP and read_returns($past(CORE_IN.rx_char))) ##1 (!RX_POP || $past(HOST_REQ.rd)))
        else $error("receive read did not pop one character");

    tx_push_a: assert property ( // R4
        wr_at(`URSEL_A_HOLD) and !s.cfg.lctl[`URSEL_LCTL_DIV_BIT]
        |=> TX_PUSH && TX_CHAR == $past(HOST_REQ.wdata))
        else $error("transmit write not queued");

    push_cause_a: assert property ( // R4
        TX_PUSH |-> $past(HOST_REQ.wr) && $past(HOST_REQ.addr) == `URSEL_A_HOLD)
        else $error("transmit push without a write");

    ien_enh_a: assert property ( // R5
        wr_at(`URSEL_A_IEN) and !s.cfg.lctl[`URSEL_LCTL_DIV_BIT] && enh
        |=> CFG.ien == $past(HOST_REQ.wdata))
        else $error("interrupt enable not written");

    ien_keep_a: assert property ( // R15
        wr_at(`URSEL_A_IEN) and !s.cfg.lctl[`URSEL_LCTL_DIV_BIT] && !enh
        |=> CFG.ien[7:4] == $past(s.cfg.ien[7:4]) && CFG.ien[3:0] == $past(HOST_REQ.wdata[3:0]))
        else $error("enhanced interrupt enable bits changed");

    mctl_keep_a: assert property ( // R15
        wr_at(`URSEL_A_MCTL) and !bank && !enh |=> CFG.mctl[7:5] == $past(s.cfg.mctl[7:5]))
        else $error("enhanced modem control bits changed");

    qctl_load_a: assert property ( // R6
        wr_at(`URSEL_A_ISTAT) and (enh ? !s.cfg.lctl[`URSEL_LCTL_DIV_BIT] : !bank)
        |=> QCTL_WR && QCTL == $past(HOST_REQ.wdata))
        else $error("queue control not loaded");

    istat_read_a: assert property ( // R6
        rd_at(`URSEL_A_ISTAT) and !s.cfg.lctl[`URSEL_LCTL_DIV_BIT] && enh
        |=> read_returns($past(CORE_IN.istat)))
        else $error("interrupt status not returned");

    lctl_any_a: assert property ( // R7
        wr_at(`URSEL_A_LCTL) |=> CFG.lctl == $past(HOST_REQ.wdata))
        else $error("line control not written");

    lstat_wr_a: assert property ( // R8
        wr_at(`URSEL_A_LSTAT) and !bank && !HOST_REQ.rd |=> $stable(CFG) && !TX_PUSH && !QCTL_WR)
        else $error("line status write had an effect");

    msctl_gate_a: assert property ( // R9
        wr_at(`URSEL_A_MSTAT) and !bank |=> CFG.msctl == ($past(enh)
            ? ($past(HOST_REQ.wdata) & `URSEL_MSCTL_MASK) : $past(s.cfg.msctl)))
        else $error("modem status write port misgated");

    scratch_a: assert property ( // R10
        wr_at(`URSEL_A_SCRATCH) and !bank && !lvl_sel |=> CFG.scratch == $past(HOST_REQ.wdata)
        and $stable(CFG.mode))
        else $error("scratch register not written");

    level_mode_a: assert property ( // R11
        wr_at(`URSEL_A_SCRATCH) and !bank && lvl_sel |=> CFG.mode == $past(HOST_REQ.wdata)
        and $stable(CFG.scratch))
        else $error("mode select not written");

    level_read_a: assert property ( // R12
        (rd_at(`URSEL_A_HOLD) and bank) or (rd_at(`URSEL_A_SCRATCH) and !bank && lvl_sel)
        |=> read_returns($past(CORE_IN.level)) and !RX_POP)
        else $error("fifo level not returned");

    thresh_a: assert property ( // R12
        wr_at(`URSEL_A_HOLD) and bank |=> CFG.thresh == $past(HOST_REQ.wdata) && !TX_PUSH)
        else $error("threshold not written");

    efunc_a: assert property ( // R13
        wr_at(`URSEL_A_ISTAT) and bank |=> CFG.efunc == $past(HOST_REQ.wdata) && !QCTL_WR)
        else $error("enhanced function not written");

    pause_two_a: assert property ( // R14
        wr_at(`URSEL_A_SCRATCH) and bank |=> CFG.pause2 == $past(HOST_REQ.wdata)
        and $stable(CFG.scratch))
        else $error("second pause character not written");

    read_once_a: assert property (
        !HOST_REQ.rd |=> !RD_VALID)
        else $error("read answer without a read");

    // Read side of several registers, the causes of the receive pop and queue control pulses, and the feature and first resume writes
    logic dl_shut;
    assign dl_shut = !s.cfg.lctl[`URSEL_LCTL_DIV_BIT];

    div_lo_read_a: assert property ( // R1
        rd_at(`URSEL_A_HOLD) and dl_open && !div_zero
        |=> read_returns($past(s.cfg.div_lo)))
        else $error("divisor low byte misread");

    frac_read_a: assert property ( // R2
        rd_at(`URSEL_A_ISTAT) and dl_open && enh
        |=> read_returns($past(s.cfg.div_frac)))
        else $error("fraction misread");

    // A stray pop would silently drop a received character
    pop_cause_a: assert property ( // R4
        RX_POP
        |-> $past(HOST_REQ.rd) && $past(HOST_REQ.addr) == `URSEL_A_HOLD && $past(dl_shut))
        else $error("receive pop without a read");

    ien_read_a: assert property ( // R5
        rd_at(`URSEL_A_IEN) and dl_shut
        |=> read_returns($past(s.cfg.ien)))
        else $error("interrupt enable misread");

    // Compatible mode hides the enhanced status bits
    istat_hide_a: assert property ( // R15
        rd_at(`URSEL_A_ISTAT) and !bank && !enh
        |=> read_returns($past(CORE_IN.istat) & ~`URSEL_ISTAT_ENH_MASK))
        else $error("status bits not hidden");

    qctl_cause_a: assert property ( // R6
        QCTL_WR
        |-> $past(HOST_REQ.wr) && $past(HOST_REQ.addr) == `URSEL_A_ISTAT)
        else $error("queue control pulse without a write");

    lctl_read_a: assert property ( // R7
        rd_at(`URSEL_A_LCTL)
        |=> read_returns($past(s.cfg.lctl)))
        else $error("line control misread");

    lstat_read_a: assert property ( // R8
        rd_at(`URSEL_A_LSTAT) and !bank
        |=> read_returns($past(CORE_IN.lstat)))
        else $error("line status misread");

    mstat_read_a: assert property ( // R9
        rd_at(`URSEL_A_MSTAT) and !bank
        |=> read_returns($past(CORE_IN.mstat)))
        else $error("modem status misread");

    scratch_read_a: assert property ( // R10
        rd_at(`URSEL_A_SCRATCH) and !bank && !lvl_sel
        |=> read_returns($past(s.cfg.scratch)))
        else $error("scratch misread");

    feat_write_a: assert property ( // R13
        wr_at(`URSEL_A_IEN) and bank
        |=> CFG.feat == $past(HOST_REQ.wdata) and $stable(CFG.ien))
        else $error("feature control not written");

    resume_one_a: assert property ( // R14
        wr_at(`URSEL_A_MCTL) and bank
        |=> CFG.res1 == $past(HOST_REQ.wdata) and $stable(CFG.mctl))
        else $error("first resume character not written");
endmodule : ursel_top
`default_nettype wire

// ===== include/ursel_params.svh
// Constants for the UART register select block: offsets, keys, masks.
// Assumes inclusion by the design modules by bare name.
`ifndef URSEL_PARAMS_SVH
`define URSEL_PARAMS_SVH
// Register offsets on the three-bit host address
`define URSEL_A_HOLD 3'h0
`define URSEL_A_IEN 3'h1
`define URSEL_A_ISTAT 3'h2
`define URSEL_A_LCTL 3'h3
`define URSEL_A_MCTL 3'h4
`define URSEL_A_LSTAT 3'h5
`define URSEL_A_MSTAT 3'h6
`define URSEL_A_SCRATCH 3'h7
// Line control value that opens the enhanced bank
`define URSEL_BANK_KEY 8'hBF
// Field positions
`define URSEL_LCTL_DIV_BIT 7
`define URSEL_EFUNC_ENH_BIT 4
`define URSEL_FEAT_LVL_BIT 6
// Bits writable, or for interrupt status readable, only with enhanced functions on
`define URSEL_IEN_ENH_MASK 8'hF0
`define URSEL_MCTL_ENH_MASK 8'hE0
`define URSEL_ISTAT_ENH_MASK 8'h30
// Modem status write port keeps its low nibble at zero
`define URSEL_MSCTL_MASK 8'hF0
// Reset values
`define URSEL_REG_RST 8'h00
`define URSEL_DIV_ZERO 8'h00
`endif

// ===== include/ursel_pkg.sv
// Types shared by the UART register select block.
// Assumes ursel_params.svh on the include path.
package ursel_pkg;
    // Register reached by the current access, separately for read and write
    typedef enum logic [4:0] {
        SEL_NONE, SEL_REV, SEL_IDENT, SEL_DIV_LO, SEL_DIV_HI, SEL_DIV_FRAC,
        SEL_HOLD, SEL_IEN, SEL_ISTAT, SEL_QCTL, SEL_LCTL, SEL_MCTL, SEL_LSTAT,
        SEL_MSTAT, SEL_MSCTL, SEL_SCRATCH, SEL_LEVEL, SEL_MODE, SEL_THRESH,
        SEL_FEAT, SEL_EFUNC, SEL_RES1, SEL_RES2, SEL_PAUSE1, SEL_PAUSE2
    } ursel_sel_t;

    // One host access: strobes, address and write data
    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ursel_req_t;

    // Live values from the UART core
    typedef struct packed {
        logic [7:0] rx_char;
        logic [7:0] istat;
        logic [7:0] lstat;
        logic [7:0] mstat;
        logic [7:0] level;
    } ursel_core_t;

    // Stored register contents handed to the core
    typedef struct packed {
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [7:0] div_frac;
        logic [7:0] ien;
        logic [7:0] lctl;
        logic [7:0] mctl;
        logic [7:0] msctl;
        logic [7:0] scratch;
        logic [7:0] mode;
        logic [7:0] thresh;
        logic [7:0] feat;
        logic [7:0] efunc;
        logic [7:0] res1;
        logic [7:0] res2;
        logic [7:0] pause1;
        logic [7:0] pause2;
    } ursel_cfg_t;

    // Whole state of the top module
    typedef struct packed {
        ursel_cfg_t cfg;
        logic [7:0] rdata;
        logic rvalid;
        logic tx_push;
        logic [7:0] tx_char;
        logic rx_pop;
        logic qctl_wr;
        logic [7:0] qctl;
    } ursel_state_t;
endpackage : ursel_pkg

// ===== hdl/ursel_decode.sv
// Address decode: picks the register reached by reads and by writes.
// Assumes the bank inputs come from registered line and feature state.
`timescale 1ns/100ps
`default_nettype none
`include "ursel_params.svh"
module ursel_decode (
    input wire logic [2:0] addr,
    input wire logic [7:0] lctl,
    input wire logic enh,
    input wire logic lvl_sel,
    input wire logic div_zero,
    output ursel_pkg::ursel_sel_t rd_sel,
    output ursel_pkg::ursel_sel_t wr_sel
);
    import ursel_pkg::*;
    logic bank;
    logic dl;
    // Key value wins over the divisor bit, which it also carries
    assign bank = (lctl == `URSEL_BANK_KEY);
    assign dl = lctl[`URSEL_LCTL_DIV_BIT] && !bank;
    // Read and write may reach different registers at one offset
    always_comb begin
        rd_sel = SEL_NONE;
        wr_sel = SEL_NONE;
        unique case (addr)
            `URSEL_A_HOLD: begin
                if (bank) begin
                    rd_sel = SEL_LEVEL;
                    wr_sel = SEL_THRESH;
                end else if (dl) begin
                    rd_sel = div_zero ? SEL_REV : SEL_DIV_LO;
                    wr_sel = SEL_DIV_LO;
                end else begin
                    rd_sel = SEL_HOLD;
                    wr_sel = SEL_HOLD;
                end
            end
            `URSEL_A_IEN: begin
                if (bank) begin
                    rd_sel = SEL_FEAT;
                    wr_sel = SEL_FEAT;
                end else if (dl) begin
                    rd_sel = div_zero ? SEL_IDENT : SEL_DIV_HI;
                    wr_sel = SEL_DIV_HI;
                end else begin
                    rd_sel = SEL_IEN;
                    wr_sel = SEL_IEN;
                end
            end
            `URSEL_A_ISTAT: begin
                if (bank) begin
                    rd_sel = SEL_EFUNC;
                    wr_sel = SEL_EFUNC;
                end else if (dl && enh) begin
                    rd_sel = SEL_DIV_FRAC;
                    wr_sel = SEL_DIV_FRAC;
                end else begin
                    rd_sel = SEL_ISTAT;
                    wr_sel = SEL_QCTL;
                end
            end
            `URSEL_A_LCTL: begin
                rd_sel = SEL_LCTL;
                wr_sel = SEL_LCTL;
            end
            `URSEL_A_MCTL: begin
                rd_sel = bank ? SEL_RES1 : SEL_MCTL;
                wr_sel = bank ? SEL_RES1 : SEL_MCTL;
            end
            `URSEL_A_LSTAT: begin
                rd_sel = bank ? SEL_RES2 : SEL_LSTAT;
                wr_sel = bank ? SEL_RES2 : SEL_NONE;
            end
            `URSEL_A_MSTAT: begin
                rd_sel = bank ? SEL_PAUSE1 : SEL_MSTAT;
                wr_sel = bank ? SEL_PAUSE1 : (enh ? SEL_MSCTL : SEL_NONE);
            end
            `URSEL_A_SCRATCH: begin
                if (bank) begin
                    rd_sel = SEL_PAUSE2;
                    wr_sel = SEL_PAUSE2;
                end else begin
                    rd_sel = lvl_sel ? SEL_LEVEL : SEL_SCRATCH;
                    wr_sel = lvl_sel ? SEL_MODE : SEL_SCRATCH;
                end
            end
        endcase
    end
endmodule : ursel_decode
`default_nettype wire

// ===== hdl/ursel_rdmux.sv
// Read multiplexer: the byte returned for the selected register.
// Assumes the select comes from ursel_decode in the same cycle.
`timescale 1ns/100ps
`default_nettype none
`include "ursel_params.svh"
module ursel_rdmux (
    input wire ursel_pkg::ursel_sel_t sel,
    input wire ursel_pkg::ursel_cfg_t cfg,
    input wire ursel_pkg::ursel_core_t core,
    input wire logic [7:0] rev,
    input wire logic [7:0] ident,
    input wire logic enh,
    output logic [7:0] rd_byte
);
    import ursel_pkg::*;
    // Write-only and unmapped selections read as zero
    always_comb begin
        rd_byte = 8'h00;
        unique case (sel)
            SEL_REV: rd_byte = rev;
            SEL_IDENT: rd_byte = ident;
            SEL_DIV_LO: rd_byte = cfg.div_lo;
            SEL_DIV_HI: rd_byte = cfg.div_hi;
            SEL_DIV_FRAC: rd_byte = cfg.div_frac;
            SEL_HOLD: rd_byte = core.rx_char;
            SEL_IEN: rd_byte = cfg.ien;
            // Enhanced status bits hidden in compatible mode
            SEL_ISTAT: rd_byte = enh ? core.istat : (core.istat & ~`URSEL_ISTAT_ENH_MASK); // R15
            SEL_LCTL: rd_byte = cfg.lctl;
            SEL_MCTL: rd_byte = cfg.mctl;
            SEL_LSTAT: rd_byte = core.lstat;
            SEL_MSTAT: rd_byte = core.mstat;
            SEL_SCRATCH: rd_byte = cfg.scratch;
            SEL_LEVEL: rd_byte = core.level;
            SEL_FEAT: rd_byte = cfg.feat;
            SEL_EFUNC: rd_byte = cfg.efunc;
            SEL_RES1: rd_byte = cfg.res1;
            SEL_RES2: rd_byte = cfg.res2;
            SEL_PAUSE1: rd_byte = cfg.pause1;
            SEL_PAUSE2: rd_byte = cfg.pause2;
            default: rd_byte = 8'h00;
        endcase
    end
endmodule : ursel_rdmux
`default_nettype wire

// ===== test/ursel_host_model.sv
// Host processor model: one-cycle read and write strobes on the register bus.
// Assumes each task is called just after a rising edge of clk.
`timescale 1ns/100ps
`default_nettype none
module ursel_host_model (
    input wire logic clk,
    output ursel_pkg::ursel_req_t req
);
    import ursel_pkg::*;
    // Bus starts idle with no strobe
    initial req = '0;
    // Present one access and hold it through the sampling edge
    task automatic access(input logic rd, input logic wr, input logic [2:0] addr, input logic [7:0] wdata);
        req <= '{rd: rd, wr: wr, addr: addr, wdata: wdata};
        @(posedge clk);
    endtask : access
    // Released lines flip, so a stale address or byte never looks valid
    task automatic release_bus();
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
        @(posedge clk);
    endtask : release_bus
endmodule : ursel_host_model
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the UART register select block.
// Assumes the host model and package are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ursel_pkg::*;
    localparam logic [7:0] REV = 8'h5A; // Arbitrary value
    localparam logic [7:0] IDN = 8'hA5; // Arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    ursel_core_t core = '0;
    ursel_req_t req;
    ursel_cfg_t cfg;
    logic [7:0] rd_data, tx_char, qctl, d, sc;
    logic rd_valid, tx_push, rx_pop, qctl_wr;
    logic [63:0] rnd;
    logic [9:0] note;
    logic [9:0] expq[$];
    int fail_count = 0;
    int checked = 0;

    // Free-running clock at 100 MHz
    always #5 clk = ~clk;

    ursel_host_model ursel_host_model_inst (.clk(clk), .req(req));
    ursel_top #(.REV_CODE(REV), .IDENT_CODE(IDN)) ursel_top_inst (.CLK(clk), .RST(rst), .HOST_REQ(req),
        .CORE_IN(core), .RD_DATA(rd_data), .RD_VALID(rd_valid), .CFG(cfg), .TX_PUSH(tx_push),
        .TX_CHAR(tx_char), .RX_POP(rx_pop), .QCTL_WR(qctl_wr), .QCTL(qctl));

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Kind 0 plain read, 1 read that pops a character
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [1:0] k);
        expq.push_back({k, e});
        ursel_host_model_inst.access(1'b1, 1'b0, a, 8'($urandom));
    endtask : rd

    // Kind 2 expects a transmit push, 3 a queue control load, 0 nothing
    task automatic wr(input logic [2:0] a, input logic [7:0] v, input logic [1:0] k);
        if (k != 2'd0) begin
            expq.push_back({k, v});
        end
        ursel_host_model_inst.access(1'b0, 1'b1, a, v);
    endtask : wr

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // Each result pulse retires the oldest note; a pulse with no note is a fault
    always @(negedge clk) begin
        if (rst === 1'b0 && {rd_valid, tx_push, qctl_wr} !== 3'b000) begin
            if (expq.size() == 0) begin
                fail_count++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, {rd_valid, tx_push, qctl_wr}, 3'b000);
            end else begin
                note = expq.pop_front();
                case (note[9:8])
                    2'd0, 2'd1: chk({rd_valid, rx_pop, tx_push, qctl_wr, rd_data}, {1'b1, note[8], 2'b00, note[7:0]});
                    2'd2: chk({rd_valid, tx_push, qctl_wr, tx_char}, {3'b010, note[7:0]});
                    default: chk({rd_valid, tx_push, qctl_wr, qctl}, {3'b001, note[7:0]});
                endcase
            end
        end
    end

    // Main sequence: compatible bank, divisor bank, enhanced bank, enhanced modes
    initial begin
        void'($urandom(32'h8b622551));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rnd = {$urandom, $urandom};
        core <= rnd[39:0];
        @(posedge clk);
        chk(cfg, '0);
        chk({rd_valid, tx_push, rx_pop, qctl_wr}, 4'h0);
        sc = 8'($urandom);
        d = 8'($urandom);
        // Compatible bank, enhanced bits locked; back-to-back write then read
        wr(3'h1, 8'hFF, 2'd0);
        rd(3'h1, 8'h0F, 2'd0);
        wr(3'h4, 8'hFF, 2'd0);
        rd(3'h4, 8'h1F, 2'd0);
        wr(3'h7, sc, 2'd0);
        rd(3'h7, sc, 2'd0);
        rd(3'h0, core.rx_char, 2'd1);
        wr(3'h0, d, 2'd2);
        rd(3'h2, core.istat & 8'hCF, 2'd0);
        wr(3'h2, ~d, 2'd3);
        wr(3'h5, d, 2'd0);
        rd(3'h5, core.lstat, 2'd0);
        rd(3'h6, core.mstat, 2'd0);
        wr(3'h6, 8'hFF, 2'd0);
        ursel_host_model_inst.release_bus();
        chk({cfg.msctl, cfg.ien, cfg.mctl}, {8'h00, 8'h0F, 8'h1F});
        // Divisor bank: codes while both bytes are zero, then the bytes themselves
        wr(3'h3, 8'h80, 2'd0);
        rd(3'h0, REV, 2'd0);
        rd(3'h1, IDN, 2'd0);
        d = 8'($urandom) | 8'h01;
        wr(3'h0, d, 2'd0);
        wr(3'h1, ~d, 2'd0);
        rd(3'h0, d, 2'd0);
        rd(3'h1, ~d, 2'd0);
        rd(3'h2, core.istat & 8'hCF, 2'd0);
        // Enhanced bank opened by the key value
        wr(3'h3, 8'hBF, 2'd0);
        wr(3'h2, 8'h10, 2'd0);
        wr(3'h1, 8'h40, 2'd0);
        rd(3'h2, 8'h10, 2'd0);
        rd(3'h1, 8'h40, 2'd0);
        rd(3'h0, core.level, 2'd0);
        d = 8'($urandom);
        wr(3'h0, d, 2'd0);
        for (int i = 4; i < 8; i++) begin
            wr(3'(i), 8'(d + i), 2'd0);
        end
        for (int i = 4; i < 8; i++) begin
            rd(3'(i), 8'(d + i), 2'd0);
        end
        rd(3'h3, 8'hBF, 2'd0);
        ursel_host_model_inst.release_bus();
        chk(cfg.thresh, d);
        // Enhanced functions on: fraction, unlocked bits, write-only ports
        wr(3'h3, 8'h80, 2'd0);
        wr(3'h2, ~d, 2'd0);
        rd(3'h2, ~d, 2'd0);
        wr(3'h3, 8'h03, 2'd0);
        wr(3'h1, 8'hFF, 2'd0);
        rd(3'h1, 8'hFF, 2'd0);
        rd(3'h2, core.istat, 2'd0);
        wr(3'h6, d, 2'd0);
        rd(3'h6, core.mstat, 2'd0);
        rd(3'h7, core.level, 2'd0);
        wr(3'h7, ~d, 2'd0);
        ursel_host_model_inst.release_bus();
        chk({cfg.msctl, cfg.mode, cfg.scratch}, {d & 8'hF0, ~d, sc});
        // Bounded drain of outstanding notes
        for (int n = 0; n < 8 && expq.size() > 0; n++) begin
            @(posedge clk);
        end
        if (expq.size() > 0) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, expq.size(), 0);
        end
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
